/* hw/request_match_filter.sv */
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "request_match_filter_defs.svh"
// What this block does
// R1: bit 31 set lets isochronous requests pass the filter
// R2: bit 30 set lets non-coherent requests pass the filter
// R3: two 10-bit opcode keys, bits 28:19 and 18:9, top bits 11, reset 0
// R4: bit 3, reset 1, disables opcode compare so all opcodes match
// R5: bit 5 passes far-memory requests, bit 4 near-memory, both reset 1
// R6: bit 1, reset 1, passes requests to the local node
// R7: bit 0, reset 1, passes requests to a remote node
// R8: software writes 0x0000003B to turn filtering off; with that value this block still drops isochronous and non-coherent requests
// R9: software writes low byte 0x33 when using opcode keys
// R10: each slice keeps its own counters; software sums slices
// R11: events counted per slice; attribution only via thread filter
// R12: software applies one filter criterion at a time
// R13: reserved bits 29, 8:6 and 2 read zero, writes ignored
module request_match_filter
  import request_match_filter_pkg::*;
#(
  parameter int OPC_WIDTH = 10,
  parameter int COUNT_WIDTH = 48,
  parameter int OCC_WIDTH = 5,
  parameter logic [31:0] SLICE_ID = 32'h0000_0001 // arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // request table insert, one per cycle at most
  input wire logic insert_valid_i,
  input wire logic [OPC_WIDTH-1:0] insert_opcode_i,
  input wire logic insert_isoc_i,
  input wire logic insert_noncoh_i,
  input wire logic insert_near_mem_i,
  input wire logic insert_remote_i,
  // occupancy: count of matching entries this cycle, supplied per class
  input wire logic [OCC_WIDTH-1:0] occupancy_i,
  input wire logic [OPC_WIDTH-1:0] occ_opcode_i,
  input wire logic occ_isoc_i,
  input wire logic occ_noncoh_i,
  input wire logic occ_near_mem_i,
  input wire logic occ_remote_i,
  // filter decisions, registered
  output logic insert_match_o,
  output logic [OCC_WIDTH-1:0] occupancy_match_o,
  output logic [31:0] thread_filter_o
);
  localparam int KEY_W = OPC_WIDTH - 2;

  bus_state_type bus_q;
  bus_state_type bus_d;
  logic [31:0] filter_q;
  logic [31:0] filter_d;
  logic [31:0] thread_q;
  logic [31:0] thread_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic clear_q;
  logic clear_d;
  logic ins_match_q;
  logic ins_match_d;
  logic [OCC_WIDTH-1:0] occ_match_q;
  logic [OCC_WIDTH-1:0] occ_match_d;
  logic ins_hit_a;
  logic ins_hit_b;
  logic occ_hit_a;
  logic occ_hit_b;
  logic [COUNT_WIDTH-1:0] ins_count;
  logic [COUNT_WIDTH-1:0] occ_count;
  logic bus_req;
  logic [KEY_W-1:0] key_a;
  logic [KEY_W-1:0] key_b;

  // merge byte lanes of a write under a mask of writable bits
  function automatic logic [31:0] lane_write(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] sel,
    input logic [31:0] mask
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction : lane_write

  // decide whether a request with these attributes passes the filter
  function automatic logic passes(
    input logic [31:0] f,
    input logic hit_a,
    input logic hit_b,
    input logic isoc,
    input logic noncoh,
    input logic near_mem,
    input logic remote
  );
    logic opc_ok;
    logic mem_ok;
    logic node_ok;
    logic attr_ok;
    opc_ok = f[`RMF_ALL_OPC_BIT] | hit_a | hit_b; // R4
    mem_ok = near_mem ? f[`RMF_NEAR_MEM_BIT] : f[`RMF_FAR_MEM_BIT]; // R5
    node_ok = remote ? f[`RMF_REMOTE_BIT] : f[`RMF_LOCAL_BIT]; // R6 R7
    // plain requests always pass; flagged ones need their enable
    attr_ok = (!isoc | f[`RMF_ISOC_BIT]) // R1
      & (!noncoh | f[`RMF_NONCOH_BIT]); // R2
    return opc_ok & mem_ok & node_ok & attr_ok;
  endfunction : passes

  assign key_a = filter_q[`RMF_OPC_A_LO +: KEY_W]; // R3
  assign key_b = filter_q[`RMF_OPC_B_LO +: KEY_W]; // R3
  assign bus_req = cyc_i & stb_i & (bus_q == bus_idle);

  // insert and occupancy paths each have their own pair of comparators; only the keys are shared
  opcode_compare #(.WIDTH(OPC_WIDTH)) u_ins_a (
    .key_i(key_a),
    .opcode_i(insert_opcode_i),
    .hit_o(ins_hit_a)
  );
  opcode_compare #(.WIDTH(OPC_WIDTH)) u_ins_b (
    .key_i(key_b),
    .opcode_i(insert_opcode_i),
    .hit_o(ins_hit_b)
  );
  opcode_compare #(.WIDTH(OPC_WIDTH)) u_occ_a (
    .key_i(key_a),
    .opcode_i(occ_opcode_i),
    .hit_o(occ_hit_a)
  );
  opcode_compare #(.WIDTH(OPC_WIDTH)) u_occ_b (
    .key_i(key_b),
    .opcode_i(occ_opcode_i),
    .hit_o(occ_hit_b)
  );

  // filter decisions, one cycle behind the request
  always_comb begin
    ins_match_d = insert_valid_i & passes(filter_q, ins_hit_a, ins_hit_b,
      insert_isoc_i, insert_noncoh_i, insert_near_mem_i, insert_remote_i);
    occ_match_d = passes(filter_q, occ_hit_a, occ_hit_b, occ_isoc_i,
      occ_noncoh_i, occ_near_mem_i, occ_remote_i) ? occupancy_i : '0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ins_match_q <= 1'b0;
      occ_match_q <= '0;
    end else begin
      ins_match_q <= ins_match_d;
      occ_match_q <= occ_match_d;
    end
  end

  // this slice's own counters; no cross-slice totals are kept here
  event_counter #(.WIDTH(COUNT_WIDTH), .INC_WIDTH(1)) u_ins_cnt ( // R10
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(clear_q),
    .inc_i(ins_match_q), // R11
    .count_o(ins_count)
  );
  event_counter #(.WIDTH(COUNT_WIDTH), .INC_WIDTH(OCC_WIDTH)) u_occ_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(clear_q),
    .inc_i(occ_match_q), // R10
    .count_o(occ_count)
  );

  // wishbone register file: one-cycle ack, unmapped reads return zero
  always_comb begin
    bus_d = bus_idle;
    filter_d = filter_q;
    thread_d = thread_q;
    rdata_d = rdata_q;
    clear_d = 1'b0;
    if (bus_req) begin
      bus_d = bus_ack;
      rdata_d = 32'h0000_0000;
      if (we_i) begin
        case (adr_i)
          `RMF_FILTER_ADDR: begin
            filter_d = lane_write(filter_q, dat_i, sel_i,
              `RMF_FILTER_MASK); // R13
          end
          `RMF_STATE_THREAD_ADDR: begin
            thread_d = lane_write(thread_q, dat_i, sel_i,
              `RMF_STATE_THREAD_MASK); // R11
          end
          `RMF_COUNT_CLEAR_ADDR: begin
            clear_d = sel_i[0] & dat_i[0];
          end
          default: begin
            clear_d = 1'b0;
          end
        endcase
      end else begin
        case (adr_i)
          `RMF_FILTER_ADDR: rdata_d = filter_q;
          `RMF_STATE_THREAD_ADDR: rdata_d = thread_q;
          `RMF_INSERT_COUNT_ADDR: rdata_d = ins_count[31:0];
          `RMF_OCCUPANCY_COUNT_ADDR: rdata_d = occ_count[31:0];
          `RMF_SLICE_ID_ADDR: rdata_d = SLICE_ID;
          default: rdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q <= bus_idle;
      filter_q <= `RMF_FILTER_RESET; // R3 R4 R5 R6 R7
      thread_q <= `RMF_STATE_THREAD_RESET;
      rdata_q <= 32'h0000_0000;
      clear_q <= 1'b0;
    end else begin
      bus_q <= bus_d;
      filter_q <= filter_d;
      thread_q <= thread_d;
      rdata_q <= rdata_d;
      clear_q <= clear_d;
    end
  end

  assign ack_o = (bus_q == bus_ack);
  assign dat_o = rdata_q;
  assign insert_match_o = ins_match_q;
  assign occupancy_match_o = occ_match_q;
  assign thread_filter_o = thread_q;

  // reserved bits never hold a one
  reserved_zero_a: assert property ( // R13
    @(posedge clk_i) disable iff (rst_i)
    (filter_q & ~`RMF_FILTER_MASK) == 32'h0000_0000)
    else $error("reserved filter bits set");

  // an isochronous insert is dropped when bit 31 is clear
  isoc_block_a: assert property ( // R1
    @(posedge clk_i) disable iff (rst_i)
    insert_valid_i && insert_isoc_i && !filter_q[`RMF_ISOC_BIT]
    |=> !insert_match_o)
    else $error("isoc insert passed with bit clear");

  noncoh_block_a: assert property ( // R2
    @(posedge clk_i) disable iff (rst_i)
    insert_valid_i && insert_noncoh_i && !filter_q[`RMF_NONCOH_BIT]
    |=> !insert_match_o)
    else $error("non-coherent insert passed with bit clear");

  opcode_miss_a: assert property ( // R3
    @(posedge clk_i) disable iff (rst_i)
    insert_valid_i && !filter_q[`RMF_ALL_OPC_BIT]
    && insert_opcode_i != {`RMF_OPC_TOP, key_a}
    && insert_opcode_i != {`RMF_OPC_TOP, key_b}
    |=> !insert_match_o)
    else $error("unmatched opcode passed");

  all_opcodes_a: assert property ( // R4
    @(posedge clk_i) disable iff (rst_i)
    insert_valid_i && filter_q[`RMF_ALL_OPC_BIT] && !insert_isoc_i
    && !insert_noncoh_i && insert_near_mem_i
    && filter_q[`RMF_NEAR_MEM_BIT] && !insert_remote_i
    && filter_q[`RMF_LOCAL_BIT] |=> insert_match_o)
    else $error("all-opcode insert dropped");

  far_mem_a: assert property ( // R5
    @(posedge clk_i) disable iff (rst_i)
    insert_valid_i && !insert_near_mem_i && !filter_q[`RMF_FAR_MEM_BIT]
    |=> !insert_match_o)
    else $error("far-memory insert passed with bit clear");

  // near-memory inserts need bit 4
  near_mem_a: assert property ( // R5
    @(posedge clk_i) disable iff (rst_i)
    insert_valid_i && insert_near_mem_i && !filter_q[`RMF_NEAR_MEM_BIT]
    |=> !insert_match_o)
    else $error("near-memory insert passed with bit clear");

  // occupancy path uses the same filter, so it must drop too
  occ_far_mem_a: assert property ( // R5
    @(posedge clk_i) disable iff (rst_i)
    !occ_near_mem_i && !filter_q[`RMF_FAR_MEM_BIT]
    |=> occupancy_match_o == '0)
    else $error("far-memory occupancy passed with bit clear");

  local_node_a: assert property ( // R6
    @(posedge clk_i) disable iff (rst_i)
    insert_valid_i && !insert_remote_i && !filter_q[`RMF_LOCAL_BIT]
    |=> !insert_match_o)
    else $error("local insert passed with bit clear");

  remote_node_a: assert property ( // R7
    @(posedge clk_i) disable iff (rst_i)
    insert_valid_i && insert_remote_i && !filter_q[`RMF_REMOTE_BIT]
    |=> !insert_match_o)
    else $error("remote insert passed with bit clear");

  insert_count_a: assert property ( // R10
    @(posedge clk_i) disable iff (rst_i)
    insert_match_o && !clear_q && !(&ins_count)
    |=> ins_count == $past(ins_count) + 1'b1)
    else $error("insert counter missed a match");

  // a clear wins over any increment in the same cycle
  count_clear_a: assert property ( // R10
    @(posedge clk_i) disable iff (rst_i)
    clear_q |=> ins_count == '0 && occ_count == '0)
    else $error("counters not cleared");
endmodule : request_match_filter

/* include/request_match_filter_defs.svh */
`ifndef REQUEST_MATCH_FILTER_DEFS_SVH
`define REQUEST_MATCH_FILTER_DEFS_SVH

// register byte addresses on the wishbone slave
`define RMF_FILTER_ADDR 8'h00
`define RMF_STATE_THREAD_ADDR 8'h04
`define RMF_INSERT_COUNT_ADDR 8'h08
`define RMF_OCCUPANCY_COUNT_ADDR 8'h0C
`define RMF_COUNT_CLEAR_ADDR 8'h10
`define RMF_SLICE_ID_ADDR 8'h14

// request match filter field positions
`define RMF_ISOC_BIT 31
`define RMF_NONCOH_BIT 30
`define RMF_OPC_B_HI 28
`define RMF_OPC_B_LO 19
`define RMF_OPC_A_HI 18
`define RMF_OPC_A_LO 9
`define RMF_FAR_MEM_BIT 5
`define RMF_NEAR_MEM_BIT 4
`define RMF_ALL_OPC_BIT 3
`define RMF_LOCAL_BIT 1
`define RMF_REMOTE_BIT 0

// writable bits and reset value of the request match filter
`define RMF_FILTER_MASK 32'hDFFF_FE3B
`define RMF_FILTER_RESET 32'h0000_003B
// upper two opcode bits are forced to binary 11 for the compare; the register keeps what was written
`define RMF_OPC_TOP 2'h3

// state/thread filter: only bits 26:17 and 8:0 are kept
`define RMF_STATE_THREAD_MASK 32'h07FE_01FF
`define RMF_STATE_THREAD_RESET 32'h0000_0000

`endif

/* include/request_match_filter_pkg.sv */
package request_match_filter_pkg;
  // node target of a queued request
  typedef enum logic {
    target_local,
    target_remote
  } target_type;

  // bus slave phase
  typedef enum logic {
    bus_idle,
    bus_ack
  } bus_state_type;
endpackage : request_match_filter_pkg

/* hw/opcode_compare.sv */
`timescale 1ns/10ps
`include "request_match_filter_defs.svh"
// one opcode comparator; the stored key has its top two bits forced
module opcode_compare
  import request_match_filter_pkg::*;
#(
  parameter int WIDTH = 10
) (
  input wire logic [WIDTH-3:0] key_i,
  input wire logic [WIDTH-1:0] opcode_i,
  output logic hit_o
);
  // top bits of the key are fixed, so only opcodes in that group can hit
  always_comb begin
    hit_o = (opcode_i == {`RMF_OPC_TOP, key_i}); // R3
  end
endmodule : opcode_compare

/* hw/event_counter.sv */
`timescale 1ns/10ps
`include "request_match_filter_defs.svh"
// per-slice event counter with saturation and clear
module event_counter
  import request_match_filter_pkg::*;
#(
  parameter int WIDTH = 48,
  parameter int INC_WIDTH = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic [INC_WIDTH-1:0] inc_i,
  output logic [WIDTH-1:0] count_o
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic [WIDTH:0] sum;

  // saturate rather than wrap so a long run never looks small
  always_comb begin
    sum = {1'b0, count_q} + {{(WIDTH + 1 - INC_WIDTH){1'b0}}, inc_i};
    count_d = count_q;
    if (clear_i) begin
      count_d = '0;
    end else if (sum[WIDTH]) begin
      count_d = '1;
    end else begin
      count_d = sum[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count_o = count_q;
endmodule : event_counter

/* dv/request_match_filter_tb.sv */
`timescale 1ns/10ps
`include "request_match_filter_defs.svh"
module request_match_filter_tb;
  localparam logic [31:0] SLICE_TAG = 32'h0000_00A7; // arbitrary value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o;
  logic insert_valid_i = 1'b0;
  logic [9:0] insert_opcode_i = 10'h000;
  logic [3:0] ins_attr = 4'h0;
  logic [4:0] occupancy_i = 5'h00;
  logic [9:0] occ_opcode_i = 10'h000;
  logic [3:0] occ_attr = 4'h0;
  logic insert_match_o;
  logic [4:0] occupancy_match_o;
  logic [31:0] thread_filter_o;
  int num_errors = 0;
  int n_compared = 0;
  int ins_cnt = 0;
  int occ_cnt = 0;

  // 20 MHz clock
  always #25 clk_i = ~clk_i;

  request_match_filter #(.SLICE_ID(SLICE_TAG)) i_request_match_filter (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .insert_valid_i(insert_valid_i),
    .insert_opcode_i(insert_opcode_i), .insert_isoc_i(ins_attr[3]),
    .insert_noncoh_i(ins_attr[2]), .insert_near_mem_i(ins_attr[1]),
    .insert_remote_i(ins_attr[0]), .occupancy_i(occupancy_i),
    .occ_opcode_i(occ_opcode_i), .occ_isoc_i(occ_attr[3]),
    .occ_noncoh_i(occ_attr[2]), .occ_near_mem_i(occ_attr[1]),
    .occ_remote_i(occ_attr[0]), .insert_match_o(insert_match_o),
    .occupancy_match_o(occupancy_match_o),
    .thread_filter_o(thread_filter_o)
  );

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one classic cycle; hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    logic got;
    got = 1'b0;
    q = 32'h0000_0000;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) begin
        got = 1'b1;
        q = dat_o;
      end
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (!got) begin
      num_errors++;
      $display("wrong value bus ack expected 1 seen 0");
      conclude();
    end
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, 4'hF, d, q);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] a,
                    input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 4'hF, 32'h0000_0000, q);
    check(what, q, exp);
  endtask : rd

  // attr is {isoc, noncoh, near_mem, remote}; same class on both paths
  task automatic probe(input logic [9:0] opc, input logic [3:0] attr,
                       input logic exp);
    @(posedge clk_i);
    insert_valid_i <= 1'b1;
    insert_opcode_i <= opc;
    ins_attr <= attr;
    occupancy_i <= 5'h13;
    occ_opcode_i <= opc;
    occ_attr <= attr;
    @(posedge clk_i);
    insert_valid_i <= 1'b0;
    occupancy_i <= 5'h00;
    #1;
    check("insert match", {31'h0, insert_match_o}, {31'h0, exp});
    check("occupancy match", {27'h0, occupancy_match_o},
          exp ? 32'h0000_0013 : 32'h0000_0000);
    ins_cnt += int'(exp);
    occ_cnt += exp ? 19 : 0;
  endtask : probe

  // main sequence; 12 cycles of reset first
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("filter reset", `RMF_FILTER_ADDR, 32'h0000_003B);
    rd("thread reset", `RMF_STATE_THREAD_ADDR, 32'h0000_0000);
    check("thread out", thread_filter_o, 32'h0000_0000);
    $display("test reset values done");
    wr(`RMF_FILTER_ADDR, 32'hFFFF_FFFF);
    rd("filter ones", `RMF_FILTER_ADDR, 32'hDFFF_FE3B);
    begin : lane_write
      logic [31:0] q;
      wb(1'b1, `RMF_FILTER_ADDR, 4'h1, 32'hFFFF_FFC0, q);
    end
    rd("filter lane0", `RMF_FILTER_ADDR, 32'hDFFF_FE00);
    rd("unmapped", 8'hFC, 32'h0000_0000);
    rd("slice id", `RMF_SLICE_ID_ADDR, SLICE_TAG);
    wr(`RMF_STATE_THREAD_ADDR, 32'hFFFF_FFFF);
    rd("thread ones", `RMF_STATE_THREAD_ADDR, 32'h07FE_01FF);
    check("thread out", thread_filter_o, 32'h07FE_01FF);
    $display("test register access done");
    // counters start from a known zero before the match traffic
    wr(`RMF_COUNT_CLEAR_ADDR, 32'h0000_0001);
    ins_cnt = 0;
    occ_cnt = 0;
    wr(`RMF_FILTER_ADDR, 32'h0000_003B);
    probe(10'h001, 4'b0000, 1'b1);
    probe(10'h2F0, 4'b0011, 1'b1);
    probe(10'h001, 4'b1000, 1'b0);
    probe(10'h001, 4'b0100, 1'b0);
    wr(`RMF_FILTER_ADDR, 32'h8000_003B);
    probe(10'h001, 4'b1000, 1'b1);
    probe(10'h001, 4'b0100, 1'b0);
    wr(`RMF_FILTER_ADDR, 32'h4000_003B);
    probe(10'h001, 4'b0100, 1'b1);
    wr(`RMF_FILTER_ADDR, 32'h0000_003A);
    probe(10'h001, 4'b0001, 1'b0);
    probe(10'h001, 4'b0000, 1'b1);
    wr(`RMF_FILTER_ADDR, 32'h0000_0039);
    probe(10'h001, 4'b0000, 1'b0);
    probe(10'h001, 4'b0001, 1'b1);
    wr(`RMF_FILTER_ADDR, 32'h0000_002B);
    probe(10'h001, 4'b0010, 1'b0);
    probe(10'h001, 4'b0000, 1'b1);
    wr(`RMF_FILTER_ADDR, 32'h0000_001B);
    probe(10'h001, 4'b0000, 1'b0);
    probe(10'h001, 4'b0010, 1'b1);
    $display("test attribute filter done");
    // key b 0x35A in 28:19, key a 0x3A5 in 18:9, low byte 0x33
    wr(`RMF_FILTER_ADDR, 32'h1AD7_4A33);
    rd("filter keys", `RMF_FILTER_ADDR, 32'h1AD7_4A33);
    probe(10'h3A5, 4'b0000, 1'b1);
    probe(10'h35A, 4'b0001, 1'b1);
    probe(10'h3A6, 4'b0000, 1'b0);
    probe(10'h35B, 4'b0000, 1'b0);
    $display("test opcode filter done");
    rd("insert count", `RMF_INSERT_COUNT_ADDR, 32'(ins_cnt));
    rd("occupancy count", `RMF_OCCUPANCY_COUNT_ADDR, 32'(occ_cnt));
    wr(`RMF_COUNT_CLEAR_ADDR, 32'h0000_0001);
    rd("insert cleared", `RMF_INSERT_COUNT_ADDR, 32'h0000_0000);
    rd("clear reads 0", `RMF_COUNT_CLEAR_ADDR, 32'h0000_0000);
    $display("test counters done");
    conclude();
  end
endmodule : request_match_filter_tb
